// [rtl/timer_ch2_interrupt_enable.v]
// Function
// - First register bit 8 gates first overflow.
// - First register bits 7..0 gate capture flags.
// - Second register bit 8 gates second overflow.
// - Second register bits 7..0 gate match flags.
// - Reserved bits 15..9 read zero, ignore writes.
// - All enable bits reset to zero.
// - Second bit 7 gates channel H flag.
`include "ch2_irq_enable_map.vh"
`default_nettype none

module timer_ch2_interrupt_enable (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire first_overflow_flag,
  input wire [7:0] capcmp_flag,
  input wire second_overflow_flag,
  input wire [7:0] match_flag,
  output wire first_overflow_irq,
  output wire [7:0] capcmp_irq,
  output wire second_overflow_irq,
  output wire [7:0] match_irq
);

  // --------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------
  wire access_w;
  wire sel_first;
  wire sel_second;
  wire sel_flags;
  wire sel_irqs;
  wire mapped;
  reg pready_q;
  reg pslverr_q;
  wire [8:0] first_en;
  wire [8:0] second_en;
  wire [8:0] first_flags;
  wire [8:0] second_flags;
  wire [8:0] first_irq_q;
  wire [8:0] second_irq_q;
  wire [31:0] rdata_d;

  // Access phase is one cycle once entered; pready raised in the setup cycle
  assign access_w = psel & penable & pready_q;
  assign sel_first = (paddr == `ADDR_CAPTURE_OVERFLOW_EN);
  assign sel_second = (paddr == `ADDR_COMPARE_OVERFLOW_EN);
  assign sel_flags = (paddr == `ADDR_FLAG_STATUS);
  assign sel_irqs = (paddr == `ADDR_IRQ_STATUS);
  assign mapped = sel_first | sel_second | sel_flags | sel_irqs;

  // Zero wait states: ready is flopped from the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~mapped;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // --------------------------------------------------------------
  // Enable registers
  // --------------------------------------------------------------
  // Software is trusted to write zero above bit 8; nothing checks it
  apb_enable_reg u_first_en (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(access_w & pwrite & sel_first),
    .wdata(pwdata[15:0]),
    .enable_q(first_en)
  );

  apb_enable_reg u_second_en (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(access_w & pwrite & sel_second),
    .wdata(pwdata[15:0]),
    .enable_q(second_en)
  );

  // --------------------------------------------------------------
  // Request gating
  // --------------------------------------------------------------
  // Flag bit 8 is overflow, 7..0 channels H..A; second bank uses the
  // compare flag of the same letter, so bit 7 is channel H not F
  assign first_flags = {first_overflow_flag, capcmp_flag};
  assign second_flags = {second_overflow_flag, match_flag};

  irq_gate_bank u_first_gate (
    .pclk(pclk),
    .presetn(presetn),
    .flag(first_flags),
    .enable(first_en),
    .irq_q(first_irq_q)
  );

  irq_gate_bank u_second_gate (
    .pclk(pclk),
    .presetn(presetn),
    .flag(second_flags),
    .enable(second_en),
    .irq_q(second_irq_q)
  );

  assign first_overflow_irq = first_irq_q[`EN_OVERFLOW_BIT];
  assign capcmp_irq = first_irq_q[`EN_CHAN_MSB:`EN_CHAN_LSB];
  assign second_overflow_irq = second_irq_q[`EN_OVERFLOW_BIT];
  assign match_irq = second_irq_q[`EN_CHAN_MSB:`EN_CHAN_LSB];

  // --------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------
  // Unused upper bits are zero-filled, so reserved bits read zero
  assign rdata_d = sel_first ? {23'h00_0000, first_en} :
                   sel_second ? {23'h00_0000, second_en} :
                   sel_flags ? {7'h00, second_flags, 7'h00, first_flags} :
                   sel_irqs ? {7'h00, second_irq_q, 7'h00, first_irq_q} :
                   `RDATA_ZERO;

  // Read data registered in the setup cycle, valid with pready
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `RDATA_ZERO;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rdata_d;
    end
  end

endmodule

`default_nettype wire

// [rtl/ch2_irq_enable_map.vh]
`ifndef CH2_IRQ_ENABLE_MAP_VH
`define CH2_IRQ_ENABLE_MAP_VH

// --------------------------------------------------------------
// Register byte offsets on the APB
// --------------------------------------------------------------
`define ADDR_CAPTURE_OVERFLOW_EN 12'h000
`define ADDR_COMPARE_OVERFLOW_EN 12'h004
`define ADDR_FLAG_STATUS 12'h008
`define ADDR_IRQ_STATUS 12'h00C

// --------------------------------------------------------------
// Field layout of the two enable registers
// --------------------------------------------------------------
`define EN_REG_WIDTH 16
`define EN_IMPL_BITS 9
`define EN_OVERFLOW_BIT 8
`define EN_CHAN_MSB 7
`define EN_CHAN_LSB 0
`define EN_RESET 9'h000

// --------------------------------------------------------------
// Layout of the status view registers
// --------------------------------------------------------------
`define STAT_SECOND_LSB 16
`define STAT_SECOND_MSB 24

// --------------------------------------------------------------
// Bus answers
// --------------------------------------------------------------
`define RDATA_ZERO 32'h0000_0000
`define ADDR_WIDTH 12

`endif

// [rtl/irq_gate_bank.v]
`include "ch2_irq_enable_map.vh"
`default_nettype none

// --------------------------------------------------------------
// One enable register's worth of request gating
// --------------------------------------------------------------
module irq_gate_bank (
  input wire pclk,
  input wire presetn,
  input wire [8:0] flag,
  input wire [8:0] enable,
  output reg [8:0] irq_q
);

  // Plain AND per bit, registered only so the top drives from flops;
  // no edge detection, request follows flag and enable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= `EN_RESET;
    end else begin
      irq_q <= flag & enable;
    end
  end

endmodule

`default_nettype wire

// [rtl/apb_enable_reg.v]
`include "ch2_irq_enable_map.vh"
`default_nettype none

// --------------------------------------------------------------
// One 16-bit enable register: 9 live bits, 7 reserved
// --------------------------------------------------------------
module apb_enable_reg (
  input wire pclk,
  input wire presetn,
  input wire wr_en,
  input wire [15:0] wdata,
  output reg [8:0] enable_q
);

  // Reserved bits 15..9 are never stored, so writes to them vanish
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= `EN_RESET;
    end else if (wr_en) begin
      enable_q <= wdata[`EN_OVERFLOW_BIT:`EN_CHAN_LSB];
    end
  end

endmodule

`default_nettype wire

// [verif/ch2_irq_flag_source.sv]
`default_nettype none
// Timer flag bank: flags change on the clock edge, as the counter logic sets them
module flag_source (
  input wire logic pclk,
  input wire logic [17:0] cmd,
  output logic [17:0] flags = 18'h0_0000
);
  timeunit 1ns;
  timeprecision 1ns;
  // Registered so that flags never move in the design's sampling step
  always @(posedge pclk) begin
    flags <= cmd;
  end
endmodule
`default_nettype wire

// [verif/ch2_irq_sva.sv]
`default_nettype none
module ch2_irq_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic first_overflow_flag,
  input wire logic [7:0] capcmp_flag,
  input wire logic second_overflow_flag,
  input wire logic [7:0] match_flag,
  input wire logic first_overflow_irq,
  input wire logic [7:0] capcmp_irq,
  input wire logic second_overflow_irq,
  input wire logic [7:0] match_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Request gating and reserved-bit read checks
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_OV1: assert property (first_overflow_irq |-> $past(first_overflow_flag)) else $error("ovf1 request");
  AST_CAP: assert property ((capcmp_irq & ~$past(capcmp_flag)) == 8'h00) else $error("capture request");
  AST_OV2: assert property (second_overflow_irq |-> $past(second_overflow_flag)) else $error("ovf2 request");
  AST_MAT: assert property ((match_irq & ~$past(match_flag)) == 8'h00) else $error("match request");
  AST_MAT_H: assert property (match_irq[7] |-> $past(match_flag[7])) else $error("match h request");
  AST_RSVD: assert property (pready && !pwrite && paddr < 12'h008 |-> prdata[31:9] == 23'h00_0000) else $error("rsvd");
  // Enables are clear after reset, so nothing may be requested for two edges
  AST_RST: assert property ($rose(presetn) |-> ({first_overflow_irq, capcmp_irq, second_overflow_irq,
    match_irq} == 18'h0_0000)[*2]) else $error("request after reset");
  // Idle bus means the enable cannot move, so a held flag keeps its request
  AST_HOLD: assert property (first_overflow_irq && first_overflow_flag && !psel && !$past(psel) |=>
    first_overflow_irq) else $error("request dropped");
  cover property (first_overflow_irq);
  cover property (match_irq[7]);
  cover property (second_overflow_irq && match_irq == 8'hFF);
endmodule
bind timer_ch2_interrupt_enable ch2_irq_sva u_sva (.pclk, .presetn, .psel, .pwrite, .paddr, .prdata, .pready,
  .first_overflow_flag, .capcmp_flag, .second_overflow_flag, .match_flag, .first_overflow_irq, .capcmp_irq,
  .second_overflow_irq, .match_irq);
`default_nettype wire

// [verif/timer_ch2_interrupt_enable_tb_top.sv]
`default_nettype none
module timer_ch2_interrupt_enable_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd;
  logic [17:0] cmd = 18'h0_0000;
  wire [17:0] flg;
  wire [31:0] prdata;
  wire pready, pslverr, ov1, ov2;
  wire [7:0] cap, mat;
  int fails = 0, total_checks = 0;
  flag_source u_src (.pclk, .cmd, .flags(flg));
  timer_ch2_interrupt_enable u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .first_overflow_flag(flg[17]), .capcmp_flag(flg[16:9]), .second_overflow_flag(flg[8]),
    .match_flag(flg[7:0]), .first_overflow_irq(ov1), .capcmp_irq(cap), .second_overflow_irq(ov2), .match_irq(mat));
  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  initial forever #5 pclk = ~pclk;
  task automatic finish_test;
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  // APB transfer; the request holds until pready is seen at an edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Flags and requests are both registered, so allow three edges
  task automatic settle;
    repeat (3) @(posedge pclk);
  endtask
  task automatic t_reset;
    cmd <= 18'h3_FFFF;
    settle;
    chk("irq", 32'h0000_0000, {14'h0000, ov1, cap, ov2, mat});
    bus(1'b0, 12'h000, 32'h0000_0000);
    chk("en_a", 32'h0000_0000, rd);
  endtask
  // Walk opposite bits through the two registers to catch swapped lanes
  task automatic t_walk;
    for (int i = 0; i < 9; i++) begin
      bus(1'b1, 12'h000, 32'h0000_0001 << i);
      bus(1'b1, 12'h004, 32'h0000_0100 >> i);
      settle;
      chk("irq_a", 32'h0000_0001 << i, {ov1, cap});
      chk("irq_b", 32'h0000_0100 >> i, {ov2, mat});
    end
  endtask
  task automatic t_rsvd;
    bus(1'b1, 12'h000, 32'h0000_FFFF);
    bus(1'b1, 12'h004, 32'h0000_FFFF);
    bus(1'b0, 12'h004, 32'h0000_0000);
    chk("en_b", 32'h0000_01FF, rd);
    for (int k = 0; k < 2; k++) begin
      cmd <= k ? 18'h2_A5A5 : 18'h1_5A5A;
      settle;
      chk("irq", k ? 32'h0002_A5A5 : 32'h0001_5A5A, {14'h0000, ov1, cap, ov2, mat});
    end
    // Flag and request views: second bank in the upper half, first in the lower
    bus(1'b0, 12'h008, 32'h0000_0000);
    chk("flag_view", 32'h01A5_0152, rd);
    bus(1'b0, 12'h00C, 32'h0000_0000);
    chk("irq_view", 32'h01A5_0152, rd);
  endtask
  // Refused access must leave the enables alone; reset then clears them
  task automatic t_err_rst;
    bus(1'b1, 12'h010, 32'h0000_0000);
    chk("pslverr", 32'h0000_0001, {31'h0000_0000, err});
    bus(1'b0, 12'h000, 32'h0000_0000);
    chk("en_a", 32'h0000_01FF, rd);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, 12'h004, 32'h0000_0000);
    chk("en_b", 32'h0000_0000, rd);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_walk;
    t_rsvd;
    t_err_rst;
    finish_test;
  end
  // The tests need about 130 cycles; 2000 means a hang
  initial begin
    repeat (2000) @(posedge pclk);
    fails++;
    finish_test;
  end
endmodule
`default_nettype wire
